// *** six_ch_pkg.sv ***
package six_ch_pkg;

    // timing base
    localparam int CLK_MHZ = 100;
    localparam int BLANK_US = 20;
    localparam int BLANK_CYC = BLANK_US * CLK_MHZ;
    localparam int FILTER_US = 100;
    localparam int FILTER_CYC = FILTER_US * CLK_MHZ;
    localparam int OVL_WIN_US = 10;
    localparam int OVL_WIN_CYC = OVL_WIN_US * CLK_MHZ;
    localparam int OFF_BASE_US = 50;
    localparam int OFF_BASE_CYC = OFF_BASE_US * CLK_MHZ;
    localparam int PEAK_BASE_US = 100;
    localparam int PEAK_BASE_CYC = PEAK_BASE_US * CLK_MHZ;
    localparam int CNT_W = 24;

    localparam int NUM_CH = 6;
    localparam int NUM_REG = 3;
    localparam int LEVEL_W = 3;

    // serial frame layout
    localparam int FRAME_BITS = 16;
    localparam int CMD_LSB = 12;
    localparam int CMD_W = 4;
    localparam int DATA_W = 12;
    localparam int ONOFF_LSB = 6;
    localparam logic [3:0] CMD_ONOFF = 4'h1;
    localparam logic [3:0] CMD_GLOBAL = 4'h2;
    localparam logic [3:0] CMD_CH1 = 4'h4;
    localparam logic [3:0] CMD_CH2 = 4'h5;
    localparam logic [3:0] CMD_CH3 = 4'h6;

    // global command data bits
    localparam int GL_OR_BIT = 0;
    localparam int GL_LATCH_BIT = 1;
    localparam int GL_SIXTH_FAULT_OR_OVERTEMP_FLAG_BIT = 2;
    localparam int GL_HS_LSB = 3;

    // per-channel regulator command data fields
    localparam int RC_MODE_LSB = 0;
    localparam int RC_PEAK_LSB = 2;
    localparam int RC_HOLD_LSB = 5;
    localparam int RC_PTIME_LSB = 8;
    localparam int RC_OFFT_LSB = 10;
    localparam int RC_SEL_W = 2;
    localparam logic [1:0] MODE_ONOFF = 2'h0;
    localparam logic [1:0] MODE_HOLD = 2'h1;
    localparam logic [1:0] MODE_PH_MIN = 2'h2;
    localparam logic [1:0] MODE_PH_PROG = 2'h3;

    // register map (byte addresses)
    localparam logic [3:0] ADDR_FRAME = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_CONFIG = 4'h8;
    localparam int ST_GATE_LSB = 0;
    localparam int ST_FAULT_LSB = 8;
    localparam int ST_OTBLK_LSB = 16;
    localparam int ST_DIEOT_BIT = 24;
    localparam int ST_FSHUT_BIT = 25;
    localparam int CF_ON_LSB = 0;
    localparam int CF_OR_BIT = 8;
    localparam int CF_LATCH_BIT = 9;
    localparam int CF_SIXTH_FAULT_OR_OVERTEMP_FLAG_BIT = 10;
    localparam int CF_HS_LSB = 12;
    localparam logic [2:0] HS_RESET = 3'h7;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_COND = 3'b010,
        PH_OFFT = 3'b100
    } phase_e;

endpackage

// *** six_channel_switch_control.sv ***
// The register addresses and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
module six_channel_switch_control #(
    parameter int FILTER_CYC = six_ch_pkg::FILTER_CYC,
    parameter int OFF_BASE_CYC = six_ch_pkg::OFF_BASE_CYC,
    parameter int PEAK_BASE_CYC = six_ch_pkg::PEAK_BASE_CYC
) (
    input wire logic ref_clk, // system clock
    input wire logic rst_n, // synchronous reset
    input wire logic [3:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte lanes
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall
    input wire logic [5:0] parIn, // parallel channel requests
    input wire logic forced_shutdown_input, // common shutdown, high = off
    input wire logic [5:0] overTemp, // per-channel sensor
    input wire logic dieHot, // logic-area sensor
    input wire logic [5:0] offFault, // open load or bypass while off
    input wire logic [2:0] currentAbove, // comparator, current over level
    input wire logic serCsN, // serial chip select, active low
    input wire logic serClk, // serial clock
    input wire logic serIn, // serial data in
    output logic serOut, // serial data out
    output logic serOutEnN, // low while serOut drives
    output logic [5:0] gateOut, // channel drive
    output logic [8:0] levelCode, // threshold code per regulated channel
    output logic [2:0] highSideSel, // channels four to six side select
    output logic [5:0] parallel_fault_outputs // diagnostic outputs
);
    import six_ch_pkg::*;

    if (FILTER_CYC < 1 || FILTER_CYC >= (1 << CNT_W) ||
        OFF_BASE_CYC < 1 || (OFF_BASE_CYC << 3) >= (1 << CNT_W) ||
        PEAK_BASE_CYC < 1 || (PEAK_BASE_CYC << 3) >= (1 << CNT_W)) begin : g_chk
        $error("timing parameter out of counter range");
    end

    typedef struct packed {
        logic [5:0] inS1, inS2;
        logic [5:0] otS1, otS2;
        logic [5:0] offS1, offS2;
        logic [2:0] abS1, abS2;
        logic fsS1, fsS2, hotS1, hotS2;
        logic csS1, csS2, sclkS1, sclkS2, siS1, siS2;
        logic csD, sclkD;
        logic [15:0] shift;
        logic [4:0] bitCnt;
        logic so;
        logic [15:0] lastFrame;
        logic [5:0] onBits;
        logic orMode, latchMode, diag6Ot;
        logic [2:0] highSide;
        logic [2:0][11:0] chCfg;
        logic [5:0] reqD, otBlock, gate, isOt, diag;
        logic [2:0] ovl, peak;
        phase_e [2:0] phase;
        logic [2:0][CNT_W-1:0] cnt, peakCnt, ovlCnt;
        logic [6:0][CNT_W-1:0] filtCnt;
        logic [6:0] filt;
        logic [2:0][2:0] level;
        logic ack;
        logic [31:0] rdata;
    } state_s;

    state_s s, next_s;
    logic [5:0] req, rise, cmd, otTrip;
    logic [6:0] raw;
    logic doCmd;
    logic [15:0] frm;
    logic [1:0] mode;
    logic [CNT_W-1:0] offCyc, peakCyc;

    localparam logic [CNT_W-1:0] BLANK_C = CNT_W'(BLANK_CYC);
    localparam logic [CNT_W-1:0] OVL_C = CNT_W'(OVL_WIN_CYC);
    localparam logic [CNT_W-1:0] FILT_C = CNT_W'(FILTER_CYC);
    localparam logic [CNT_W-1:0] ZERO_C = '0;

    always_comb begin
        next_s = s;
        req = '0;
        rise = '0;
        cmd = '0;
        otTrip = '0;
        raw = '0;
        doCmd = 1'b0;
        frm = s.lastFrame;
        mode = MODE_ONOFF;
        offCyc = '0;
        peakCyc = '0;

        // two-stage synchronisers for every pin except the bus ports and rst_n
        next_s.inS1 = parIn;
        next_s.inS2 = s.inS1;
        next_s.otS1 = overTemp;
        next_s.otS2 = s.otS1;
        next_s.offS1 = offFault;
        next_s.offS2 = s.offS1;
        next_s.abS1 = currentAbove;
        next_s.abS2 = s.abS1;
        next_s.fsS1 = forced_shutdown_input;
        next_s.fsS2 = s.fsS1;
        next_s.hotS1 = dieHot;
        next_s.hotS2 = s.hotS1;
        next_s.csS1 = serCsN;
        next_s.csS2 = s.csS1;
        next_s.sclkS1 = serClk;
        next_s.sclkS2 = s.sclkS1;
        next_s.siS1 = serIn;
        next_s.siS2 = s.siS1;
        next_s.csD = s.csS2;
        next_s.sclkD = s.sclkS2;

        // serial port: sample on rising, shift out on falling, MSB first
        if (s.csD && !s.csS2) begin
            next_s.shift = {s.filt[6], 3'h0, s.otBlock, s.filt[5:0]};
            next_s.so = s.filt[6];
            next_s.bitCnt = '0;
        end else if (!s.csS2 && s.sclkS2 && !s.sclkD) begin
            next_s.shift = {s.shift[14:0], s.siS2};
            if (s.bitCnt != 5'h1f) begin
                next_s.bitCnt = s.bitCnt + 5'h01;
            end
        end else if (!s.csS2 && !s.sclkS2 && s.sclkD) begin
            next_s.so = s.shift[15];
        end

        // bus slave: one wait state, action at the edge waitrequest is low
        next_s.ack = (avs_read || avs_write) && !s.ack;
        if (avs_read && !s.ack) begin
            case (avs_address)
                ADDR_FRAME: next_s.rdata = {16'h0000, s.lastFrame};
                ADDR_STATUS: begin
                    next_s.rdata = '0;
                    next_s.rdata[ST_GATE_LSB +: NUM_CH] = s.gate;
                    next_s.rdata[ST_FAULT_LSB +: NUM_CH] = s.filt[5:0];
                    next_s.rdata[ST_OTBLK_LSB +: NUM_CH] = s.otBlock;
                    next_s.rdata[ST_DIEOT_BIT] = s.filt[6];
                    next_s.rdata[ST_FSHUT_BIT] = s.fsS2;
                end
                ADDR_CONFIG: begin
                    next_s.rdata = '0;
                    next_s.rdata[CF_ON_LSB +: NUM_CH] = s.onBits;
                    next_s.rdata[CF_OR_BIT] = s.orMode;
                    next_s.rdata[CF_LATCH_BIT] = s.latchMode;
                    next_s.rdata[CF_SIXTH_FAULT_OR_OVERTEMP_FLAG_BIT] = s.diag6Ot;
                    next_s.rdata[CF_HS_LSB +: 3] = s.highSide;
                end
                default: next_s.rdata = '0;
            endcase
        end
        if (avs_write && s.ack && avs_address == ADDR_FRAME) begin
            doCmd = 1'b1;
            if (avs_byteenable[0]) begin
                frm[7:0] = avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
                frm[15:8] = avs_writedata[15:8];
            end
        end
        // a complete serial frame wins over a bus write in the same cycle
        if (s.csS2 && !s.csD && s.bitCnt == 5'(FRAME_BITS)) begin
            doCmd = 1'b1;
            frm = s.shift;
        end

        if (doCmd) begin
            next_s.lastFrame = frm;
            case (frm[CMD_LSB +: CMD_W])
                CMD_ONOFF: next_s.onBits = frm[ONOFF_LSB +: NUM_CH];
                CMD_GLOBAL: begin
                    next_s.orMode = frm[GL_OR_BIT];
                    next_s.latchMode = frm[GL_LATCH_BIT];
                    next_s.diag6Ot = frm[GL_SIXTH_FAULT_OR_OVERTEMP_FLAG_BIT];
                    next_s.highSide = frm[GL_HS_LSB +: 3];
                end
                CMD_CH1: next_s.chCfg[0] = frm[DATA_W-1:0];
                CMD_CH2: next_s.chCfg[1] = frm[DATA_W-1:0];
                CMD_CH3: next_s.chCfg[2] = frm[DATA_W-1:0];
                default: ;
            endcase
        end

        for (int i = 0; i < NUM_CH; i++) begin
            req[i] = s.orMode ? (s.inS2[i] | s.onBits[i])
                              : (s.inS2[i] & s.onBits[i]);
            rise[i] = req[i] & ~s.reqD[i];
            next_s.reqD[i] = req[i];
            otTrip[i] = s.otS2[i] & s.gate[i];
            if (otTrip[i]) begin
                next_s.otBlock[i] = 1'b1;
            end else if (s.latchMode ? rise[i] : !s.otS2[i]) begin
                next_s.otBlock[i] = 1'b0;
            end
            cmd[i] = req[i] & ~s.fsS2 & ~s.otBlock[i] & ~otTrip[i];
            next_s.gate[i] = cmd[i];
            raw[i] = req[i] ? (s.otBlock[i] | otTrip[i]) : s.offS2[i];
            next_s.isOt[i] = req[i] & (s.otBlock[i] | otTrip[i]);
        end

        for (int i = 0; i < NUM_REG; i++) begin
            mode = s.chCfg[i][RC_MODE_LSB +: RC_SEL_W];
            offCyc = CNT_W'(OFF_BASE_CYC) << s.chCfg[i][RC_OFFT_LSB +: RC_SEL_W];
            peakCyc = CNT_W'(PEAK_BASE_CYC) << s.chCfg[i][RC_PTIME_LSB +: RC_SEL_W];
            if (!req[i]) begin
                next_s.ovl[i] = 1'b0;
            end
            if (mode == MODE_ONOFF || !cmd[i]) begin
                next_s.phase[i] = PH_IDLE;
                next_s.peak[i] = 1'b0;
            end else begin
                case (s.phase[i])
                    PH_IDLE: begin
                        next_s.phase[i] = PH_COND;
                        next_s.cnt[i] = BLANK_C;
                        next_s.peak[i] = (mode != MODE_HOLD);
                        next_s.peakCnt[i] = peakCyc;
                        next_s.ovlCnt[i] = OVL_C;
                    end
                    PH_COND: begin
                        if (s.ovlCnt[i] != ZERO_C) begin
                            next_s.ovlCnt[i] = s.ovlCnt[i] - 1'b1;
                            if (s.abS2[i]) begin
                                next_s.ovl[i] = 1'b1;
                            end
                        end
                        if (s.cnt[i] != ZERO_C) begin
                            next_s.cnt[i] = s.cnt[i] - 1'b1;
                        end else if (s.abS2[i]) begin
                            next_s.phase[i] = PH_OFFT;
                            next_s.cnt[i] = offCyc;
                            if (mode == MODE_PH_MIN) begin
                                next_s.peak[i] = 1'b0;
                            end
                        end
                    end
                    PH_OFFT: begin
                        if (s.cnt[i] != ZERO_C) begin
                            next_s.cnt[i] = s.cnt[i] - 1'b1;
                        end else begin
                            next_s.phase[i] = PH_COND;
                            next_s.cnt[i] = BLANK_C;
                        end
                    end
                    default: next_s.phase[i] = PH_IDLE;
                endcase
                // peak time runs from turn-on across conduct and off phases
                if (mode == MODE_PH_PROG && s.phase[i] != PH_IDLE && s.peak[i]) begin
                    if (s.peakCnt[i] != ZERO_C) begin
                        next_s.peakCnt[i] = s.peakCnt[i] - 1'b1;
                    end else begin
                        next_s.peak[i] = 1'b0;
                    end
                end
            end
            if (mode != MODE_ONOFF) begin
                next_s.gate[i] = cmd[i] && next_s.phase[i] == PH_COND;
            end
            next_s.level[i] = next_s.peak[i] ? s.chCfg[i][RC_PEAK_LSB +: LEVEL_W]
                                             : s.chCfg[i][RC_HOLD_LSB +: LEVEL_W];
            raw[i] = raw[i] | (req[i] & s.ovl[i]);
        end
        raw[6] = s.hotS2;

        // filter: a fault must last the whole filter time; drops at once when gone
        for (int k = 0; k <= NUM_CH; k++) begin
            if (raw[k]) begin
                if (s.filtCnt[k] != FILT_C) begin
                    next_s.filtCnt[k] = s.filtCnt[k] + 1'b1;
                end
            end else begin
                next_s.filtCnt[k] = '0;
            end
            next_s.filt[k] = raw[k] && s.filtCnt[k] == FILT_C;
        end

        for (int i = 0; i < NUM_CH; i++) begin
            next_s.diag[i] = s.reqD[i] ^ s.filt[i];
        end
        if (s.diag6Ot) begin
            next_s.diag[5] = ~(|(s.filt[5:0] & s.isOt) | s.filt[6]);
        end

        if (!rst_n) begin
            next_s = '0;
            next_s.highSide = HS_RESET;
            for (int i = 0; i < NUM_REG; i++) begin
                next_s.phase[i] = PH_IDLE;
            end
            next_s.csS1 = 1'b1;
            next_s.csS2 = 1'b1;
            next_s.csD = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        s <= next_s;
    end

    assign avs_waitrequest = (avs_read || avs_write) && !s.ack;
    assign avs_readdata = s.rdata;
    assign serOut = s.so;
    assign serOutEnN = s.csS2;
    assign gateOut = s.gate;
    assign levelCode = {s.level[2], s.level[1], s.level[0]};
    assign highSideSel = s.highSide;
    assign parallel_fault_outputs = s.diag;

endmodule

// *** six_channel_switch_control_assertions.sv ***
`timescale 1ns/1ps
module six_channel_switch_control_assertions #(
    parameter int FILTER_CYC = 20,
    parameter int OFF_BASE_CYC = 10,
    parameter int PEAK_BASE_CYC = 30
) (
    input wire logic ref_clk, // system clock
    input wire logic rst_n, // synchronous reset
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic avs_waitrequest, // stall
    input wire logic [5:0] parIn, // parallel requests
    input wire logic forced_shutdown_input, // common shutdown
    input wire logic [5:0] overTemp, // channel sensors
    input wire logic [5:0] offFault, // off-state faults
    input wire logic serCsN, // serial select
    input wire logic serOutEnN, // serial out enable
    input wire logic [5:0] gateOut, // channel drive
    input wire logic [2:0] highSideSel, // side select
    input wire logic [5:0] parallel_fault_outputs // diagnostic pins
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // five samples leave room for the two sync stages and the output register
    AST_FSHUT_OFF: assert property (
        forced_shutdown_input [*5] |-> gateOut == 6'h00
    ) else $error("gate on during forced shutdown");
    AST_OT_OFF: assert property (
        overTemp[2] [*5] |-> !gateOut[2]
    ) else $error("hot channel still driven");
    AST_BLANK_HOLD: assert property (
        $rose(gateOut[0]) && parIn[0] && !forced_shutdown_input |-> gateOut[0] [*8]
    ) else $error("turn-on cut inside blanking");
    AST_OFF_TIME: assert property (
        $fell(gateOut[0]) && parIn[0] && $past(parIn[0], 4) && !forced_shutdown_input
        |-> !gateOut[0] [*8]
    ) else $error("off-time too short");
    AST_FILTER: assert property (
        $rose(offFault[1]) && !parIn[1] |-> !parallel_fault_outputs[1] [*8]
    ) else $error("fault shown before filter time");
    AST_SO_HIZ: assert property (
        serCsN [*4] |-> serOutEnN
    ) else $error("serial out driven while deselected");
    AST_HS_RESET: assert property (
        $rose(rst_n) |-> highSideSel == 3'h7
    ) else $error("side select reset value wrong");
    AST_BUS_WAIT: assert property (
        $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest
    ) else $error("bus answer not after one wait state");
endmodule

// *** host_serial_model.sv ***
`timescale 1ns/1ps
module host_serial_model (
    input wire logic ref_clk, // system clock
    input wire logic serOut, // device serial out
    output logic serCsN, // chip select, active low
    output logic serClk, // serial clock, idle high
    output logic serIn, // serial data to device
    output logic [15:0] rxFrame // last frame read back
);
    initial begin
        serCsN = 1'b1;
        serClk = 1'b1;
        serIn = 1'b1;
        rxFrame = 16'h0000;
    end

    // four clocks per level: the device syncs every pin through two flops
    task automatic hold4();
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic send_frame(input logic [15:0] f, input int nbits);
        @(posedge ref_clk);
        serCsN <= 1'b0;
        hold4();
        for (int i = 15; i > 15 - nbits; i--) begin
            serClk <= 1'b0;
            serIn <= f[i];
            hold4();
            serClk <= 1'b1;
            hold4();
            // take the out bit four clocks after the rising edge, before the next falling edge moves it
            rxFrame <= {rxFrame[14:0], serOut};
        end
        serCsN <= 1'b1;
        serIn <= ~f[16 - nbits];
        hold4();
    endtask
endmodule

// *** tb_six_channel_switch_control.sv ***
`timescale 1ns/1ps
module tb_six_channel_switch_control;
    import six_ch_pkg::*;
    logic ref_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, dieHot = 1'b0;
    logic forced_shutdown_input = 1'b0;
    logic avs_waitrequest, serOut, serOutEnN, serCsN, serClk, serIn;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [5:0] parIn = 6'h00, overTemp = 6'h00, offFault = 6'h00, gateOut, parallel_fault_outputs;
    logic [2:0] currentAbove = 3'h0, highSideSel;
    logic [8:0] levelCode;
    logic [15:0] rxFrame;
    int err_count = 0, comparisons = 0, n;
    // or-select, serial bits, parallel inputs, expected gates
    logic [18:0] rows [6] = '{{1'h0, 6'h2a, 6'h33, 6'h22}, {1'h1, 6'h2a, 6'h33, 6'h3b},
        {1'h0, 6'h3f, 6'h3f, 6'h3f}, {1'h1, 6'h00, 6'h00, 6'h00},
        {1'h1, 6'h01, 6'h20, 6'h21}, {1'h0, 6'h3f, 6'h00, 6'h00}};

    six_channel_switch_control #(.FILTER_CYC(20), .OFF_BASE_CYC(10), .PEAK_BASE_CYC(30)) dut (
        .ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'h3), .avs_readdata, .avs_waitrequest, .parIn, .forced_shutdown_input,
        .overTemp, .dieHot, .offFault, .currentAbove, .serCsN, .serClk, .serIn, .serOut,
        .serOutEnN, .gateOut, .levelCode, .highSideSel, .parallel_fault_outputs);
    host_serial_model host (.ref_clk, .serOut, .serCsN, .serClk, .serIn, .rxFrame);

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic tick(input int c);
        repeat (c) @(posedge ref_clk);
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // request stands until the rising edge that samples waitrequest low; data taken there
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 100);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (k >= 100) check(1'b1, 1'b0);
    endtask

    task automatic frame(input logic [15:0] f);
        bus(1'b1, ADDR_FRAME, {16'h0000, f});
    endtask

    task automatic wrap_up();
        $display("comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        tick(20000);
        check(1'b1, 1'b0);
        wrap_up();
    end

    initial begin
        tick(2);
        rst_n <= 1'b1;
        tick(1);
        check(highSideSel, 3'h7);
        foreach (rows[i]) begin
            parIn <= rows[i][11:6];
            frame({CMD_GLOBAL, 6'h00, HS_RESET, 2'h0, rows[i][18]});
            frame({CMD_ONOFF, rows[i][17:12], 6'h00});
            tick(6);
            check(gateOut, rows[i][5:0]);
            check(parallel_fault_outputs, rows[i][5:0]);
        end
        forced_shutdown_input <= 1'b1;
        parIn <= 6'h3f;
        frame({CMD_GLOBAL, 6'h00, HS_RESET, 3'h1});
        tick(6);
        check(gateOut, 6'h00);
        forced_shutdown_input <= 1'b0;
        tick(6);
        check(gateOut, 6'h3f);
        parIn <= 6'h00;
        host.send_frame(16'h2011, 16);
        host.send_frame(16'h1fc0, 16);
        tick(6);
        check(gateOut, 6'h3f);
        check(highSideSel, 3'h2);
        host.send_frame(16'h1000, 15);
        tick(6);
        check(gateOut, 6'h3f);
        host.send_frame(16'h1000, 16);
        tick(6);
        check(gateOut, 6'h00);
        frame({CMD_GLOBAL, 6'h00, HS_RESET, 3'h3});
        parIn <= 6'h04;
        tick(6);
        overTemp <= 6'h04;
        tick(6);
        check(gateOut, 6'h00);
        overTemp <= 6'h00;
        tick(10);
        check(gateOut, 6'h00);
        bus(1'b0, ADDR_STATUS, 32'h0);
        check(rd[ST_OTBLK_LSB + 2], 1'b1);
        bus(1'b0, 4'hc, 32'h0);
        check(rd, 32'h0);
        host.send_frame(16'h0000, 16);
        check(rxFrame[8], 1'b1);
        parIn <= 6'h00;
        tick(6);
        parIn <= 6'h04;
        tick(6);
        check(gateOut, 6'h04);
        frame({CMD_GLOBAL, 6'h00, HS_RESET, 3'h1});
        overTemp <= 6'h04;
        tick(6);
        check(gateOut, 6'h00);
        overTemp <= 6'h00;
        tick(6);
        check(gateOut, 6'h04);
        parIn <= 6'h20;
        frame({CMD_GLOBAL, 6'h00, HS_RESET, 3'h5});
        offFault <= 6'h02;
        tick(10);
        check(parallel_fault_outputs, 6'h20);
        tick(30);
        check(parallel_fault_outputs, 6'h22);
        offFault <= 6'h00;
        tick(30);
        check(parallel_fault_outputs, 6'h20);
        dieHot <= 1'b1;
        tick(40);
        check(parallel_fault_outputs[5], 1'b0);
        bus(1'b0, ADDR_STATUS, 32'h0);
        check(rd[ST_DIEOT_BIT], 1'b1);
        dieHot <= 1'b0;
        parIn <= 6'h00;
        // comparator held high from turn-on also trips the overload window
        // ch1 hold-only, ch2 minimum peak time, ch3 programmed peak time of 30 cycles
        for (int k = 0; k < 3; k++) begin
            frame(k == 0 ? 16'h4061 : (k == 1 ? 16'h5056 : 16'h603b));
            parIn <= 6'h01 << k;
            currentAbove <= 3'h1 << k;
            tick(10);
            check(levelCode[3*k +: 3], k == 0 ? 3'h3 : (k == 1 ? 3'h5 : 3'h6));
            n = 0;
            while (gateOut[k] === 1'b1 && n < 3000) begin
                tick(1);
                n++;
            end
            check(n >= 1985 && n <= 2005, 1'b1);
            check(parallel_fault_outputs[k], 1'b0);
            check(levelCode[3*k +: 3], k == 0 ? 3'h3 : (k == 1 ? 3'h2 : 3'h1));
            currentAbove <= 3'h0;
            n = 0;
            while (gateOut[k] === 1'b0 && n < 100) begin
                tick(1);
                n++;
            end
            check(n >= 9 && n <= 14, 1'b1);
            parIn <= 6'h00;
            tick(6);
        end
        wrap_up();
    end
endmodule

bind six_channel_switch_control six_channel_switch_control_assertions #(
    .FILTER_CYC(FILTER_CYC), .OFF_BASE_CYC(OFF_BASE_CYC), .PEAK_BASE_CYC(PEAK_BASE_CYC)
) chk (.ref_clk, .rst_n, .avs_read, .avs_write, .avs_waitrequest, .parIn,
    .forced_shutdown_input, .overTemp, .offFault, .serCsN, .serOutEnN, .gateOut,
    .highSideSel, .parallel_fault_outputs);
